// ---- core/resonance_tracking_control.v ----
// Resonance tracking, braking and impedance control with AHB-Lite registers
`timescale 1ns/10ps
`include "tracking_consts.vh"
module resonance_tracking_control (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire [31:0] haddr_in,
   input  wire [1:0]  htrans_in,
   input  wire        hwrite_in,
   input  wire [2:0]  hsize_in,
   input  wire        hsel_in,
   input  wire        hready_in,
   input  wire [31:0] hwdata_in,
   output reg  [31:0] hrdata_out,
   output reg         hreadyout_out,
   output reg         hresp_out,
   input  wire        zero_cross_in,
   input  wire [15:0] backemf_amp_in,
   input  wire [15:0] load_sense_in,
   input  wire        playing_in,
   input  wire        frame_freq_valid_in,
   input  wire [15:0] frame_period_in,
   input  wire [15:0] drive_level_in,
   output reg  [15:0] drive_period_out,
   output reg  [15:0] drive_level_out,
   output reg         brake_out,
   output reg  [15:0] v2i_factor_out,
   output reg         event_pending_out
);
   // Pin inputs synchronised
   reg        zc_s1_r, zc_s2_r, zc_d_r, play_s1_r, play_s2_r, play_d_r, ffv_s1_r, ffv_s2_r;
   reg [15:0] bemf_s1_r, bemf_s2_r, load_s1_r, load_s2_r, fper_s1_r, fper_s2_r, lvl_s1_r, lvl_s2_r;
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         {zc_s1_r, zc_s2_r, zc_d_r, play_s1_r, play_s2_r, play_d_r, ffv_s1_r, ffv_s2_r} <= 8'h00;
         {bemf_s1_r, bemf_s2_r, load_s1_r, load_s2_r} <= 64'h0;
         {fper_s1_r, fper_s2_r, lvl_s1_r, lvl_s2_r} <= 64'h0;
      end else begin
         zc_s1_r <= zero_cross_in;
         zc_s2_r <= zc_s1_r;
         zc_d_r <= zc_s2_r;
         play_s1_r <= playing_in;
         play_s2_r <= play_s1_r;
         play_d_r <= play_s2_r;
         ffv_s1_r <= frame_freq_valid_in;
         ffv_s2_r <= ffv_s1_r;
         bemf_s1_r <= backemf_amp_in;
         bemf_s2_r <= bemf_s1_r;
         load_s1_r <= load_sense_in;
         load_s2_r <= load_s1_r;
         fper_s1_r <= frame_period_in;
         fper_s2_r <= fper_s1_r;
         lvl_s1_r <= drive_level_in;
         lvl_s2_r <= lvl_s1_r;
      end
   end
   wire zc_edge = zc_s2_r & ~zc_d_r;
   wire play_start = play_s2_r & ~play_d_r;
   wire play_end = ~play_s2_r & play_d_r;

   // Registers
   reg [31:0] ctrl_r;
   reg [15:0] prop_gain_r, int_gain_r, lock_lim_r, trk_bemf_r, brake_lim_r, per_cmd_r;
   reg [15:0] per_inst_r, imped_r;
   reg [2:0]  event_r, mask_r;

   // AHB-Lite address phase capture
   reg        wr_pend_r;
   reg [11:0] addr_r;
   wire       acc = hsel_in & hready_in & htrans_in[1];
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_pend_r <= 1'b0;
         addr_r <= 12'h000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         if (hready_in) begin
            wr_pend_r <= acc & hwrite_in;
            if (acc)
               addr_r <= haddr_in[11:0];
         end
      end
   end
   wire wr = wr_pend_r;
   wire wr_ctrl = wr && addr_r == `OFF_CTRL;
   wire wr_evt = wr && addr_r == `OFF_EVENT;

   // Period measurement in 1333.32 ns ticks
   reg [3:0]  tick_div_r;
   reg [15:0] per_cnt_r;
   wire tick = tick_div_r == `TICK_CYC - 1;
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         tick_div_r <= 4'h0;
         per_cnt_r <= 16'h0000;
         per_inst_r <= 16'h0000;
      end else begin
         tick_div_r <= tick ? 4'h0 : tick_div_r + 4'h1;
         if (zc_edge) begin
            per_cnt_r <= 16'h0000;
            // Half-period doubled to full period
            per_inst_r <= {per_cnt_r[14:0], 1'b0};
         end else if (tick && per_cnt_r != 16'hFFFF)
            per_cnt_r <= per_cnt_r + 16'h0001;
      end
   end
   wire [15:0] per_mean;
   period_average u_avg (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .sample_in (zc_edge),
      .period_in (per_inst_r),
      .mean_out  (per_mean)
   );

   // Tracking loop
   wire track_ok = ctrl_r[`CTL_TRACK_EN] && !ctrl_r[`CTL_WIDEBAND] && bemf_s2_r >= trk_bemf_r;
   wire [15:0] trk_per;
   wire        locked;
   pi_tracker u_pi (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .step_in       (zc_edge),
      .enable_in     (track_ok),
      .auto_gain_in  (ctrl_r[`CTL_AUTO_GAIN]),
      .nominal_in    (per_cmd_r),
      .measured_in   (per_inst_r),
      .prop_gain_in  (prop_gain_r),
      .int_gain_in   (int_gain_r),
      .lock_lim_in   (lock_lim_r),
      .drive_per_out (trk_per),
      .locked_out    (locked)
   );
   reg locked_d_r;

   // Playback sequencing: half-period count, braking, impedance
   reg [7:0]  half_cnt_r;
   reg        first_half_r, braking_r;
   reg [15:0] v2i_r;
   wire range_bad = play_s2_r && half_cnt_r > 8'h02 && !ctrl_r[`CTL_BYPASS] &&
                    (per_inst_r > `PER_MAX_50HZ || per_inst_r < `PER_MIN_300HZ);
   wire imp_bad = first_half_r && zc_edge && load_s2_r == 16'h0000;
   wire bemf_bad = ctrl_r[`CTL_COMP_EN] && braking_r == 1'b0 && bemf_s2_r == 16'hFFFF;
   wire [2:0] ev_set = {play_end & ctrl_r[`CTL_BRAKE_EN], locked & ~locked_d_r,
                        range_bad | imp_bad | bemf_bad};
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         half_cnt_r <= 8'h00;
         first_half_r <= 1'b0;
         braking_r <= 1'b0;
         brake_out <= 1'b0;
         v2i_r <= `V2I_RST;
         imped_r <= 16'h0000;
         locked_d_r <= 1'b0;
         v2i_factor_out <= `V2I_RST;
      end else begin
         locked_d_r <= locked;
         v2i_factor_out <= v2i_r;
         if (play_start) begin
            half_cnt_r <= 8'h00;
            first_half_r <= 1'b1;
         end else if (zc_edge) begin
            if (half_cnt_r != 8'hFF)
               half_cnt_r <= half_cnt_r + 8'h01;
            first_half_r <= 1'b0;
         end
         if (first_half_r && zc_edge) begin
            imped_r <= load_s2_r;
            if (!(ctrl_r[`CTL_HOLD] && ctrl_r[`CTL_MEAS_DIS]))
               v2i_r <= load_s2_r;
         end
         if (play_end && ctrl_r[`CTL_BRAKE_EN] && half_cnt_r > 8'h03)
            braking_r <= 1'b1;
         else if (braking_r && zc_edge) begin
            // Deceleration reversed at crossing: zero acceleration reached
            if (per_cnt_r >= per_inst_r[15:1] || bemf_s2_r <= brake_lim_r)
               braking_r <= 1'b0;
         end
         if (zc_edge || !braking_r)
            brake_out <= braking_r;
      end
   end

   // Drive period and level
   wire [15:0] wb_per = (ffv_s2_r && fper_s2_r <= `PER_MAX_25HZ) ? fper_s2_r : per_cmd_r;
   wire [16:0] comp = {1'b0, lvl_s2_r} - {1'b0, bemf_s2_r[15:1]};
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         drive_period_out <= `PER_CMD_RST;
         drive_level_out <= 16'h0000;
      end else begin
         if (zc_edge || !play_s2_r)
            drive_period_out <= track_ok ? trk_per : wb_per;
         if (ctrl_r[`CTL_COMP_EN] && bemf_s2_r > lvl_s2_r)
            drive_level_out <= comp[16] ? 16'h0000 : comp[15:0];
         else
            drive_level_out <= lvl_s2_r;
      end
   end

   // Register writes
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_r <= `CTL_RESET;
         prop_gain_r <= `PROP_GAIN_RST;
         int_gain_r <= `INT_GAIN_RST;
         lock_lim_r <= `LOCK_LIM_RST;
         trk_bemf_r <= `TRK_BEMF_RST;
         brake_lim_r <= `BRAKE_LIM_RST;
         per_cmd_r <= `PER_CMD_RST;
         event_r <= 3'h0;
         mask_r <= 3'h0;
         event_pending_out <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_r <= {23'h0, hwdata_in[8:0]};
         if (wr && addr_r == `OFF_PROP_GAIN)
            prop_gain_r <= hwdata_in[15:0];
         if (wr && addr_r == `OFF_INT_GAIN)
            int_gain_r <= hwdata_in[15:0];
         if (wr && addr_r == `OFF_LOCK_LIM)
            lock_lim_r <= hwdata_in[15:0];
         if (wr && addr_r == `OFF_TRK_BEMF)
            trk_bemf_r <= hwdata_in[15:0];
         if (wr && addr_r == `OFF_BRAKE_LIM)
            brake_lim_r <= hwdata_in[15:0];
         if (wr && addr_r == `OFF_PER_CMD)
            per_cmd_r <= {hwdata_in[15:7], hwdata_in[6:0]};
         if (wr && addr_r == `OFF_MASK)
            mask_r <= hwdata_in[2:0];
         event_r <= (event_r & ~(wr_evt ? hwdata_in[2:0] : 3'h0)) | ev_set;
         event_pending_out <= |(event_r & ~mask_r);
      end
   end

   // Read data, high part in bits 15:7 pairs, low seven bits in 6:0
   // Read data registered at the address phase edge, stands in the data phase
   wire [11:0] rd_addr = acc ? haddr_in[11:0] : addr_r;
   reg [31:0] rd;
   always @* begin
      case (rd_addr)
         `OFF_CTRL:      rd = ctrl_r;
         `OFF_PROP_GAIN: rd = {16'h0, prop_gain_r};
         `OFF_INT_GAIN:  rd = {16'h0, int_gain_r};
         `OFF_LOCK_LIM:  rd = {16'h0, lock_lim_r};
         `OFF_TRK_BEMF:  rd = {16'h0, trk_bemf_r};
         `OFF_BRAKE_LIM: rd = {16'h0, brake_lim_r};
         `OFF_PER_CMD:   rd = {16'h0, per_cmd_r};
         `OFF_PER_INST:  rd = {16'h0, per_inst_r};
         `OFF_PER_MEAN:  rd = {16'h0, per_mean};
         `OFF_IMPEDANCE: rd = {16'h0, imped_r};
         `OFF_V2I:       rd = {16'h0, v2i_r};
         `OFF_EVENT:     rd = {29'h0, event_r};
         `OFF_MASK:      rd = {29'h0, mask_r};
         `OFF_STATUS:    rd = {28'h0, braking_r, locked, track_ok, first_half_r};
         default:        rd = 32'h00000000;
      endcase
   end
   always @(posedge clk_in) begin
      if (!rst_n_in)
         hrdata_out <= 32'h00000000;
      else
         hrdata_out <= rd;
   end
endmodule

// ---- core/tracking_consts.vh ----
// Register offsets, field positions, reset values and timing counts
`ifndef TRACKING_CONSTS_VH
`define TRACKING_CONSTS_VH
`define OFF_CTRL        12'h000
`define OFF_PROP_GAIN   12'h004
`define OFF_INT_GAIN    12'h008
`define OFF_LOCK_LIM    12'h00C
`define OFF_TRK_BEMF    12'h010
`define OFF_BRAKE_LIM   12'h014
`define OFF_PER_CMD     12'h018
`define OFF_PER_INST    12'h01C
`define OFF_PER_MEAN    12'h020
`define OFF_IMPEDANCE   12'h024
`define OFF_V2I         12'h028
`define OFF_EVENT       12'h02C
`define OFF_MASK        12'h030
`define OFF_STATUS      12'h034
`define CTL_TRACK_EN    0
`define CTL_AUTO_GAIN   1
`define CTL_BYPASS      2
`define CTL_BRAKE_EN    3
`define CTL_HOLD        4
`define CTL_MEAS_DIS    5
`define CTL_COMP_EN     6
`define CTL_SENSE_EN    7
`define CTL_WIDEBAND    8
`define CTL_RESET       32'h000000C9
`define PROP_GAIN_RST   16'h0100
`define INT_GAIN_RST    16'h0020
`define LOCK_LIM_RST    16'h0040
`define TRK_BEMF_RST    16'h0010
`define BRAKE_LIM_RST   16'h0020
`define PER_CMD_RST     16'h0EA6
`define V2I_RST         16'h0800
// Period counts in 1333.32 ns ticks: 50 Hz -> 15000, 300 Hz -> 2500
`define PER_MAX_50HZ    16'h3A98
`define PER_MIN_300HZ   16'h09C4
`define PER_MAX_25HZ    16'h7530
`define TICK_NS         1333
`define CLK_NS          100
`define TICK_CYC        13
`define EV_ACT_FAULT    0
`define EV_LOCK         1
`define EV_BRAKE_DONE   2
`endif

// ---- core/period_average.v ----
// Mean of the last four full-period measurements
`timescale 1ns/10ps
module period_average (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire        sample_in,
   input  wire [15:0] period_in,
   output reg  [15:0] mean_out
);
   reg [15:0] hist_r [0:3];
   wire [17:0] sum = {2'b00, period_in} + {2'b00, hist_r[0]} + {2'b00, hist_r[1]} + {2'b00, hist_r[2]};
   integer i;
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (i = 0; i < 4; i = i + 1)
            hist_r[i] <= 16'h0000;
         mean_out <= 16'h0000;
      end else if (sample_in) begin
         hist_r[0] <= period_in;
         for (i = 1; i < 4; i = i + 1)
            hist_r[i] <= hist_r[i-1];
         mean_out <= sum[17:2];
      end
   end
endmodule

// ---- core/pi_tracker.v ----
// Proportional-integral period tracker with lock detect
`timescale 1ns/10ps
`include "tracking_consts.vh"
module pi_tracker (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire        step_in,
   input  wire        enable_in,
   input  wire        auto_gain_in,
   input  wire [15:0] nominal_in,
   input  wire [15:0] measured_in,
   input  wire [15:0] prop_gain_in,
   input  wire [15:0] int_gain_in,
   input  wire [15:0] lock_lim_in,
   output reg  [15:0] drive_per_out,
   output reg         locked_out
);
   reg  signed [31:0] integ_r;
   wire signed [17:0] err = $signed({2'b00, measured_in}) - $signed({2'b00, drive_per_out});
   wire [17:0] abs_err = err[17] ? -err : err;
   // Halved proportional gain once locked, for finer accuracy
   wire [15:0] kp = (auto_gain_in && locked_out) ? {1'b0, prop_gain_in[15:1]} : prop_gain_in;
   wire signed [35:0] p_term = err * $signed({2'b00, kp});
   wire signed [35:0] i_term = err * $signed({2'b00, int_gain_in});
   wire signed [31:0] integ_nxt = integ_r + $signed({{4{i_term[35]}}, i_term[35:8]});
   wire signed [31:0] sum = $signed({16'h0000, nominal_in}) + integ_nxt + $signed({{4{p_term[35]}}, p_term[35:8]});
   // Clamp to plus or minus a quarter of nominal
   wire [15:0] quarter = {2'b00, nominal_in[15:2]};
   wire [16:0] hi = {1'b0, nominal_in} + {1'b0, quarter};
   wire [15:0] lo = nominal_in - quarter;
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         integ_r       <= 32'sh0;
         drive_per_out <= `PER_CMD_RST;
         locked_out    <= 1'b0;
      end else if (!enable_in) begin
         integ_r       <= 32'sh0;
         drive_per_out <= nominal_in;
         locked_out    <= 1'b0;
      end else if (step_in) begin
         integ_r <= integ_nxt;
         if (sum > $signed({15'h0000, hi}))
            drive_per_out <= hi[15:0];
         else if (sum < $signed({16'h0000, lo}))
            drive_per_out <= lo;
         else
            drive_per_out <= sum[15:0];
         if (abs_err <= {2'b00, lock_lim_in})
            locked_out <= 1'b1;
      end
   end
endmodule

// ---- dv/rtc_props.sv ----
// Port-level checks for the resonance tracking block
`timescale 1ns/10ps
`include "tracking_consts.vh"
module rtc_props (
   input wire        clk_in,
   input wire        rst_n_in,
   input wire [31:0] haddr_in,
   input wire [1:0]  htrans_in,
   input wire        hwrite_in,
   input wire        hsel_in,
   input wire        hready_in,
   input wire [31:0] hwdata_in,
   input wire        zero_cross_in,
   input wire        playing_in,
   input wire [15:0] drive_level_in,
   input wire [31:0] hrdata_out,
   input wire        hreadyout_out,
   input wire        hresp_out,
   input wire [15:0] drive_period_out,
   input wire [15:0] drive_level_out,
   input wire        brake_out,
   input wire [15:0] v2i_factor_out,
   input wire        event_pending_out
);
   reg [8:0]  ctrl_r;
   reg [11:0] adr_r;
   reg        wr_r;
   reg [2:0]  zs_r;
   reg [3:0]  since_r;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Shadow of the control word and crossing age
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_r  <= 9'h0C9;
         wr_r    <= 1'b0;
         adr_r   <= 12'h000;
         zs_r    <= 3'h0;
         since_r <= 4'hF;
      end else begin
         wr_r    <= hsel_in & hready_in & htrans_in[1] & hwrite_in;
         adr_r   <= haddr_in[11:0];
         if (wr_r && adr_r == `OFF_CTRL) ctrl_r <= hwdata_in[8:0];
         zs_r    <= {zs_r[1:0], zero_cross_in};
         since_r <= (zs_r[1] & ~zs_r[2]) ? 4'h0 : ((since_r == 4'hF) ? 4'hF : since_r + 4'h1);
      end
   end
   sequence mask_all_wr;
      hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[11:0] == `OFF_MASK ##1 hwdata_in[2:0] == 3'h7;
   endsequence
   sequence unmapped_rd;
      hsel_in && hready_in && htrans_in[1] && !hwrite_in && haddr_in[11:0] > `OFF_STATUS;
   endsequence
   AST_READY_ALWAYS: assert property (hreadyout_out) else $error("wait state inserted");
   AST_RESP_OKAY: assert property (!hresp_out) else $error("error response");
   AST_UNMAPPED_ZERO: assert property (unmapped_rd |=> hrdata_out == 32'h0) else $error("unmapped not zero");
   AST_MASK_SILENCES: assert property (mask_all_wr |-> ##[1:2] !event_pending_out) else $error("mask ignored");
   AST_HOLD_FREEZES_FACTOR: assert property (ctrl_r[4] && ctrl_r[5] && $past(ctrl_r[4] && ctrl_r[5])
      |-> $stable(v2i_factor_out)) else $error("factor moved while held");
   AST_LEVEL_PASS: assert property ((playing_in && !ctrl_r[6] && $stable(drive_level_in))[*5]
      |-> drive_level_out == drive_level_in) else $error("level altered");
   AST_LEVEL_LOWERED: assert property ((playing_in && ctrl_r[6] && $stable(drive_level_in))[*5]
      |-> drive_level_out <= drive_level_in) else $error("level raised");
   AST_BRAKE_NEEDS_ENABLE: assert property ($rose(brake_out) |-> ctrl_r[3] && !playing_in)
      else $error("brake without enable");
   AST_PERIOD_AT_CROSSING: assert property ($changed(drive_period_out) && playing_in && $past(playing_in, 8)
      |-> since_r <= 4'h6) else $error("period changed off crossing");
   AST_BRAKE_ENDS_AT_CROSSING: assert property ($fell(brake_out) |-> since_r <= 4'h6)
      else $error("brake ended off crossing");
endmodule

// ---- dv/actuator_model.sv ----
// Behavioural resonant actuator seen through crossings and back-EMF
`timescale 1ns/10ps
module actuator_model (
   input  wire        clk_in,
   input  wire        playing_in,
   input  wire [15:0] half_cyc_in,
   input  wire [15:0] amp_in,
   output reg         zero_cross_out,
   output reg  [15:0] backemf_out
);
   reg [15:0] cnt_r;
   initial begin
      cnt_r = 16'h0000;
      zero_cross_out = 1'b0;
      backemf_out = 16'h0000;
   end
   // Keeps ringing after drive stops, amplitude quartered each crossing
   always @(posedge clk_in) begin
      if (playing_in || backemf_out != 16'h0000) begin
         cnt_r <= (cnt_r + 16'h0001 >= half_cyc_in) ? 16'h0000 : cnt_r + 16'h0001;
         zero_cross_out <= (cnt_r < 16'h0004);
         if (playing_in) backemf_out <= amp_in;
         else if (cnt_r == 16'h0000) backemf_out <= backemf_out >> 2;
      end else begin
         cnt_r <= 16'h0000;
         zero_cross_out <= 1'b0;
      end
   end
endmodule

// ---- dv/tb_resonance_tracking_control.sv ----
// Self-checking bench for the resonance tracking block
`timescale 1ns/10ps
`include "tracking_consts.vh"
module tb_resonance_tracking_control;
   localparam int HALF = 1300;
   logic        clk_in, rst_n_in, hwrite_in, hsel_in, playing_in, ffv_in, zc;
   logic        hreadyout_out, hresp_out, brake_out, event_pending_out;
   logic [1:0]  htrans_in;
   logic [31:0] haddr_in, hwdata_in, hrdata_out, v;
   logic [15:0] amp_in, sense_in, frame_in, level_in, bemf, drive_period_out, drive_level_out, v2i_out;
   int          num_errors = 0, tests_run = 0, cycles = 0, lo;
   localparam logic [11:0] RA [0:7] = '{`OFF_CTRL, `OFF_PROP_GAIN, `OFF_INT_GAIN, `OFF_LOCK_LIM, `OFF_TRK_BEMF,
      `OFF_BRAKE_LIM, `OFF_PER_CMD, `OFF_V2I};
   localparam logic [15:0] RE [0:7] = '{16'h00C9, `PROP_GAIN_RST, `INT_GAIN_RST, `LOCK_LIM_RST, `TRK_BEMF_RST,
      `BRAKE_LIM_RST, `PER_CMD_RST, `V2I_RST};
   resonance_tracking_control resonance_tracking_control_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
      .hsize_in(3'b010), .hsel_in(hsel_in), .hready_in(hreadyout_out), .hwdata_in(hwdata_in),
      .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .zero_cross_in(zc),
      .backemf_amp_in(bemf), .load_sense_in(sense_in), .playing_in(playing_in), .frame_freq_valid_in(ffv_in),
      .frame_period_in(frame_in), .drive_level_in(level_in), .drive_period_out(drive_period_out),
      .drive_level_out(drive_level_out), .brake_out(brake_out), .v2i_factor_out(v2i_out),
      .event_pending_out(event_pending_out));
   actuator_model actuator_model_i (.clk_in(clk_in), .playing_in(playing_in), .half_cyc_in(16'(HALF)),
      .amp_in(amp_in), .zero_cross_out(zc), .backemf_out(bemf));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         $display("[ERR] run length expected end seen hang");
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      haddr_in  <= {20'h0, a};
      htrans_in <= 2'b10;
      hwrite_in <= w;
      hsel_in   <= 1'b1;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      htrans_in <= 2'b00;
      hsel_in   <= 1'b0;
      hwdata_in <= wd;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      rd = hrdata_out;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] s;
      xfer(a, 1'b1, d, s);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      xfer(a, 1'b0, 32'h0, d);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(nm, exp, d);
   endtask
   task automatic rng(input string nm, input logic [31:0] got, input int lo_v, input int hi_v);
      tests_run++;
      if ((got >= lo_v && got <= hi_v) !== 1'b1) begin
         num_errors++;
         $display("[ERR] %s expected %0d to %0d seen %0d", nm, lo_v, hi_v, got);
      end
   endtask
   // Whole period in 1333.32 ns ticks, clock-rounded ticks allow some slack
   function automatic int per_exp();
      return 2 * HALF * `CLK_NS * 100 / 133332;
   endfunction
   task automatic play(input int n, input logic [15:0] a);
      amp_in     <= a;
      playing_in <= 1'b1;
      repeat (n * HALF) @(posedge clk_in);
   endtask
   task automatic stop_quiet(input string nm);
      playing_in <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < 20000 && bemf !== 16'h0000; i++) @(posedge clk_in);
      repeat (10) @(posedge clk_in);
      $display("test %s done", nm);
   endtask
   initial begin
      {hwrite_in, hsel_in, playing_in, ffv_in, htrans_in, haddr_in, hwdata_in} = '0;
      {amp_in, sense_in, frame_in, level_in} = '0;
      rst_n_in = 1'b0;
      void'($urandom(32'hDAAAB689));
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      for (int i = 0; i < 8; i++) rchk("reset value", RA[i], {16'h0, RE[i]});
      for (int i = 1; i < 6; i++) begin
         v = $urandom();
         wr(RA[i], v);
         rchk("gain or limit", RA[i], {16'h0, v[15:0]});
         wr(RA[i], {16'h0, RE[i]});
      end
      wr(12'h03C, 32'hFFFFFFFF);
      rchk("unmapped", 12'h03C, 32'h0);
      wr(`OFF_V2I, 32'h0000FFFF);
      rchk("read-only factor", `OFF_V2I, {16'h0, `V2I_RST});
      wr(`OFF_MASK, 32'h0);
      sense_in <= 16'($urandom_range(1023, 64));
      level_in <= 16'($urandom());
      play(6, 16'h0100);
      rd(`OFF_PER_INST, v);
      rng("instant period", v, per_exp() - 8, per_exp() + 8);
      rd(`OFF_PER_MEAN, v);
      rng("mean period", v, per_exp() - 8, per_exp() + 8);
      stop_quiet("out of band");
      rchk("impedance", `OFF_IMPEDANCE, {16'h0, sense_in});
      rd(`OFF_EVENT, v);
      chk("range fault", 32'h1, {31'h0, v[0]});
      chk("pending", 32'h1, {31'h0, event_pending_out});
      wr(`OFF_MASK, 32'h7);
      repeat (3) @(posedge clk_in);
      chk("masked", 32'h0, {31'h0, event_pending_out});
      wr(`OFF_EVENT, 32'h7);
      rchk("cleared", `OFF_EVENT, 32'h0);
      wr(`OFF_MASK, 32'h0);
      wr(`OFF_CTRL, 32'h000000FF);
      play(3, 16'h0100);
      rd(`OFF_STATUS, v);
      chk("tracking active", 32'h1, {31'h0, v[1]});
      rng("tracked period", drive_period_out, `PER_CMD_RST * 3 / 4, `PER_CMD_RST * 5 / 4);
      play(3, 16'h0100);
      playing_in <= 1'b0;
      lo = 0;
      while (brake_out !== 1'b1 && lo < 2 * HALF) begin @(posedge clk_in); lo++; end
      chk("brake start", 32'h1, {31'h0, brake_out});
      lo = 0;
      while (brake_out !== 1'b0 && lo < 4 * HALF) begin @(posedge clk_in); lo++; end
      chk("brake end", 32'h0, {31'h0, brake_out});
      stop_quiet("braking");
      rd(`OFF_EVENT, v);
      chk("bypass and brake done", 32'h4, v & 32'h5);
      chk("factor frozen", {16'h0, sense_in}, {16'h0, v2i_out});
      wr(`OFF_EVENT, 32'h7);
      play(2, 16'h0008);
      rd(`OFF_STATUS, v);
      chk("tracking off", 32'h0, {31'h0, v[1]});
      playing_in <= 1'b0;
      lo = 0;
      repeat (2 * HALF) begin @(posedge clk_in); if (brake_out === 1'b1) lo++; end
      chk("short sequence brake", 32'h0, lo);
      stop_quiet("short sequence");
      wr(`OFF_CTRL, 32'h00000180);
      frame_in <= 16'($urandom_range(30000, 2500));
      ffv_in <= 1'b1;
      play(4, 16'h0100);
      chk("frame period", {16'h0, frame_in}, {16'h0, drive_period_out});
      chk("level pass", {16'h0, level_in}, {16'h0, drive_level_out});
      ffv_in <= 1'b0;
      v = $urandom_range(30000, 2500);
      wr(`OFF_PER_CMD, v);
      play(2, 16'h0100);
      chk("command period", v, {16'h0, drive_period_out});
      stop_quiet("wideband");
      wrap_up();
   end
endmodule
bind resonance_tracking_control rtc_props rtc_props_i (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
   .hsel_in(hsel_in), .hready_in(hready_in), .hwdata_in(hwdata_in), .zero_cross_in(zero_cross_in),
   .playing_in(playing_in), .drive_level_in(drive_level_in), .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .drive_period_out(drive_period_out),
   .drive_level_out(drive_level_out), .brake_out(brake_out), .v2i_factor_out(v2i_factor_out),
   .event_pending_out(event_pending_out));
